// ---- hw/hwt_map.svh ----
// register offsets, field positions, reset values and tick counts
`ifndef HWT_MAP_SVH
`define HWT_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define HWT_OFF_PRELOAD 5'h00
`define HWT_OFF_CTRL 5'h04
`define HWT_OFF_COUNT 5'h08
`define HWT_OFF_STATUS 5'h0C
`define HWT_OFF_MASK 5'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define HWT_CTRL_RES_BIT 0
`define HWT_STAT_WAKE_BIT 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define HWT_PRELOAD_RST 16'h0000
`define HWT_CTRL_RST 1'h0
`define HWT_COUNT_RST 16'h0000
`define HWT_STATUS_RST 1'h0
`define HWT_MASK_RST 1'h0

// ----------------------------------------------------------------------
// tick timing: low-speed clock rate, tick periods, and the coarse tick counted in low-speed clock edges
// ----------------------------------------------------------------------
`define HWT_LSCLK_HZ 32768
`define HWT_FINE_TICK_NS 30500
`define HWT_COARSE_TICK_MS 125
`define HWT_COARSE_EDGES ((`HWT_COARSE_TICK_MS * `HWT_LSCLK_HZ) / 1000)

`endif

// ---- hw/hwt_pkg.sv ----
// types shared by the wake timer modules
package hwt_pkg;

  // ----------------------------------------------------------------------
  // bus carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
  } hwt_wb_req_type;

  // ----------------------------------------------------------------------
  // counter states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    HWT_ST_IDLE = 3'b001,
    HWT_ST_RUN = 3'b010,
    HWT_ST_DONE = 3'b100
  } hwt_state_type;

endpackage : hwt_pkg

// ---- hw/hwt_prescaler.sv ----
// resolution tick generator driven by low-speed clock edges
`timescale 1ns/1ps
`include "hwt_map.svh"
module hwt_prescaler
  import hwt_pkg::*;
#(
  parameter int COARSE_EDGES = `HWT_COARSE_EDGES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // control
  input wire logic edge_i,
  input wire logic restart_i,
  input wire logic coarse_i,
  // tick
  output logic tick_o
);

  localparam int CW = $clog2(COARSE_EDGES);
  localparam logic [CW-1:0] LAST = CW'(COARSE_EDGES - 1);

  generate
    if (COARSE_EDGES < 2) begin : g_bad
      $error("hwt_prescaler: COARSE_EDGES must be at least 2");
    end
  endgenerate

  logic [CW-1:0] div_ff;

  // ----------------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= '0;
    end else if (ce_i) begin
      if (restart_i) begin
        div_ff <= '0;
      end else if (edge_i) begin
        div_ff <= (div_ff == LAST) ? '0 : div_ff + CW'(1);
      end
    end
  end

  // fine mode ticks on every low-speed edge except one taken by a restart, i.e. one 30.5 us period
  assign tick_o = edge_i & ~restart_i & (~coarse_i | (div_ff == LAST));

endmodule : hwt_prescaler

// ---- hw/hwt_wake_timer.sv ----
// wake timer top: wishbone registers, low-speed sync and down counter
`timescale 1ns/1ps
`include "hwt_map.svh"
module hwt_wake_timer
  import hwt_pkg::*;
#(
  parameter int COARSE_EDGES = `HWT_COARSE_EDGES
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // low-speed clock pin and sleep controls
  input wire logic lsclk_i,
  input wire logic sleep_en_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // clock request and events
  output logic clk_req_o,
  output logic wake_interrupt_event_o,
  output logic irq_o
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic logic reg_hit(input logic [4:0] adr,
                                   input logic [4:0] off);
    reg_hit = (adr[4:2] == off[4:2]);
  endfunction : reg_hit

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  hwt_wb_req_type req;
  hwt_state_type state_ff;
  hwt_state_type nxt_state;
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [15:0] preload_value_ff;
  logic [15:0] nxt_preload_value;
  logic res_ff;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic pending_ff;
  logic status_ff;
  logic mask_ff;
  logic irq_ff;
  logic clk_req_ff;
  logic wake_ff;
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic req_take;
  logic wr_preload;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic ls_edge;
  logic apply;
  logic tick;
  logic reach_zero;
  logic [31:0] rd_data;
  logic unused_sleep;

  assign req = '{adr: adr_i, dat: dat_i, sel: sel_i, we: we_i};

  // the sleep input is deliberately left out of every path
  assign unused_sleep = sleep_en_i;

  // ----------------------------------------------------------------------
  // bus access
  // ----------------------------------------------------------------------
  // a request is taken once; ack follows one cycle later and drops after
  assign req_take = cyc_i & stb_i & ~ack_ff;
  assign wr_preload = req_take & req.we & reg_hit(req.adr, `HWT_OFF_PRELOAD);
  assign wr_ctrl = req_take & req.we & reg_hit(req.adr, `HWT_OFF_CTRL);
  assign wr_status = req_take & req.we & reg_hit(req.adr, `HWT_OFF_STATUS);
  assign wr_mask = req_take & req.we & reg_hit(req.adr, `HWT_OFF_MASK);

  // write completes at once; the 32 kHz side picks it up later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= req_take;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (reg_hit(req.adr, `HWT_OFF_PRELOAD)) begin
      rd_data[15:0] = preload_value_ff;
    end else if (reg_hit(req.adr, `HWT_OFF_CTRL)) begin
      rd_data[`HWT_CTRL_RES_BIT] = res_ff;
    end else if (reg_hit(req.adr, `HWT_OFF_COUNT)) begin
      rd_data[15:0] = count_ff;
    end else if (reg_hit(req.adr, `HWT_OFF_STATUS)) begin
      rd_data[`HWT_STAT_WAKE_BIT] = status_ff;
    end else if (reg_hit(req.adr, `HWT_OFF_MASK)) begin
      rd_data[`HWT_STAT_WAKE_BIT] = mask_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      if (req_take & ~req.we) begin
        dat_ff <= rd_data;
      end else if (ack_ff) begin
        dat_ff <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // preload register, byte lanes
  // ----------------------------------------------------------------------
  genvar lane;
  generate
    for (lane = 0; lane < 2; lane++) begin : g_lane
      assign nxt_preload_value[lane*8 +: 8] =
        req.sel[lane] ? req.dat[lane*8 +: 8] : preload_value_ff[lane*8 +: 8];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preload_value_ff <= `HWT_PRELOAD_RST;
    end else if (ce_i && wr_preload) begin
      preload_value_ff <= nxt_preload_value;
    end
  end

  // ----------------------------------------------------------------------
  // control and interrupt registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_ff <= `HWT_CTRL_RST;
    end else if (ce_i && wr_ctrl && req.sel[0]) begin
      res_ff <= req.dat[`HWT_CTRL_RES_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= `HWT_MASK_RST;
    end else if (ce_i && wr_mask && req.sel[0]) begin
      mask_ff <= req.dat[`HWT_STAT_WAKE_BIT];
    end
  end

  // a wake in the same cycle as a write-one-to-clear keeps the bit set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_ff <= `HWT_STATUS_RST;
    end else if (ce_i) begin
      if (reach_zero) begin
        status_ff <= 1'b1;
      end else if (wr_status && req.sel[0] &&
                   req.dat[`HWT_STAT_WAKE_BIT]) begin
        status_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else if (ce_i) begin
      irq_ff <= (status_ff | reach_zero) & mask_ff;
    end
  end

  // ----------------------------------------------------------------------
  // low-speed clock synchroniser
  // ----------------------------------------------------------------------
  // sync1 feeds sync2 only; the edge is taken between sync2 and sync3
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else if (ce_i) begin
      sync1_ff <= lsclk_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  assign ls_edge = sync2_ff & ~sync3_ff;

  // ----------------------------------------------------------------------
  // update hand-off into the counting core
  // ----------------------------------------------------------------------
  // a preload write waits for the next low-speed edge, so the core only
  // ever changes on that clock
  assign apply = pending_ff & ls_edge;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_ff <= 1'b0;
    end else if (ce_i) begin
      if (wr_preload) begin
        pending_ff <= 1'b1;
      end else if (apply) begin
        pending_ff <= 1'b0;
      end
    end
  end

  // request the clock only while an access or a pending update is live
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_req_ff <= 1'b0;
    end else if (ce_i) begin
      clk_req_ff <= req_take | (pending_ff & ~apply) | wr_preload;
    end
  end

  hwt_prescaler #(
    .COARSE_EDGES(COARSE_EDGES)
  ) u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .edge_i(ls_edge),
    .restart_i(apply),
    .coarse_i(res_ff),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------------
  assign reach_zero = (state_ff == HWT_ST_RUN) & ~apply & tick &
                      (count_ff == 16'h0001);

  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    case (state_ff)
      HWT_ST_IDLE: begin
        nxt_count = count_ff;
      end
      HWT_ST_RUN: begin
        if (tick) begin
          nxt_count = count_ff - 16'h0001;
          if (count_ff == 16'h0001) begin
            nxt_state = HWT_ST_DONE;
          end
        end
      end
      HWT_ST_DONE: begin
        nxt_count = 16'h0000;
      end
      default: begin
        nxt_state = HWT_ST_IDLE;
        nxt_count = 16'h0000;
      end
    endcase
    if (apply) begin
      if (preload_value_ff != 16'h0000) begin
        nxt_state = HWT_ST_RUN;
        nxt_count = preload_value_ff;
      end else begin
        nxt_state = HWT_ST_IDLE;
        nxt_count = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= HWT_ST_IDLE;
      count_ff <= `HWT_COUNT_RST;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_ff <= 1'b0;
    end else if (ce_i) begin
      wake_ff <= reach_zero;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign dat_o = dat_ff;
  assign ack_o = ack_ff;
  assign clk_req_o = clk_req_ff;
  assign wake_interrupt_event_o = wake_ff;
  assign irq_o = irq_ff;

endmodule : hwt_wake_timer

// ---- tb/hwt_wake_timer_props.sv ----
// port checker for the wake timer, bound to its top module
`timescale 1ns/1ps
module hwt_wake_timer_props #(
  parameter int COARSE_EDGES = 4096
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // low-speed clock and sleep
  input wire logic lsclk_i,
  input wire logic sleep_en_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // request and events
  input wire logic clk_req_o,
  input wire logic wake_interrupt_event_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------------
  sequence s_take;
    cyc_i && stb_i && ce_i && !ack_o;
  endsequence
  property p_ack_take;
    s_take |=> ack_o;
  endproperty
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i);
  endproperty
  property p_dat_idle;
    !ack_o |-> dat_o == 32'h0;
  endproperty
  a_ack_take: assert property (p_ack_take)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside ack");
  // ----------------------------------------------------------------------
  // clock request and wake
  // ----------------------------------------------------------------------
  property p_req_rise;
    $rose(clk_req_o) |-> $rose(ack_o);
  endproperty
  property p_req_ends;
    clk_req_o |-> ##[0:40] !clk_req_o;
  endproperty
  property p_wake_pulse;
    wake_interrupt_event_o |=> !wake_interrupt_event_o;
  endproperty
  property p_irq_rise;
    $rose(irq_o) |-> wake_interrupt_event_o || $past(ack_o)
      || $past(ack_o, 2);
  endproperty
  property p_irq_fall;
    $fell(irq_o) |-> $past(ack_o) || $past(ack_o, 2);
  endproperty
  a_req_rise: assert property (p_req_rise)
    else $error("clock request outside an access");
  a_req_ends: assert property (p_req_ends)
    else $error("clock request held too long");
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake event longer than one cycle");
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose without cause");
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without software");
endmodule : hwt_wake_timer_props

bind hwt_wake_timer hwt_wake_timer_props #(.COARSE_EDGES(COARSE_EDGES)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .lsclk_i(lsclk_i),
  .sleep_en_i(sleep_en_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .clk_req_o(clk_req_o),
  .wake_interrupt_event_o(wake_interrupt_event_o), .irq_o(irq_o));

// ---- tb/hwt_ls_src.sv ----
// free-running low-speed clock source beside the wake timer
`timescale 1ns/1ps
module hwt_ls_src #(
  parameter int HALF_NS = 50
) (
  output logic lsclk_o
);
  // shortened from 32.768 kHz to keep the run brief; the timer only
  // counts edges, so all expectations scale with this period
  initial begin
    lsclk_o = 1'b0;
    forever #(HALF_NS) lsclk_o = ~lsclk_o;
  end
endmodule : hwt_ls_src

// ---- tb/hwt_wake_timer_bench.sv ----
// directed bench for the wake timer over its wishbone port
`timescale 1ns/1ps
`include "hwt_map.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module hwt_wake_timer_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [15:0] held_count;
  logic sleep_en_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [4:0] adr_i = 5'h00;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic lsclk_i;
  logic [31:0] dat_o;
  logic ack_o;
  logic clk_req_o;
  logic wake_interrupt_event_o;
  logic irq_o;
  logic [31:0] rd;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  always #5 clk_i = ~clk_i;
  hwt_ls_src u_ls (.lsclk_o(lsclk_i));
  hwt_wake_timer #(.COARSE_EDGES(4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .lsclk_i(lsclk_i),
    .sleep_en_i(sleep_en_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .clk_req_o(clk_req_o),
    .wake_interrupt_event_o(wake_interrupt_event_o), .irq_o(irq_o));
  // ----------------------------------------------------------------------
  // bus and wait tasks
  // ----------------------------------------------------------------------
  task complete_run;
    $display("mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      num_errors++;
      complete_run();
    end
  endtask : wb
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdc
  // cycles from the last write until the wake pulse
  task automatic wait_wake;
    n = 0;
    while (wake_interrupt_event_o !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      num_errors++;
      complete_run();
    end
  endtask : wait_wake
  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`HWT_OFF_PRELOAD, 32'h0);
    rdc(`HWT_OFF_CTRL, 32'h0);
    rdc(`HWT_OFF_COUNT, 32'h0);
    rdc(`HWT_OFF_STATUS, 32'h0);
    rdc(`HWT_OFF_MASK, 32'h0);
    rdc(5'h14, 32'h0);
    // the request stays up through the ack cycle, so look one edge later
    @(posedge clk_i);
    `CHK(clk_req_o, 1'b0)
    wb(1'b1, `HWT_OFF_COUNT, 32'h1234);
    rdc(`HWT_OFF_COUNT, 32'h0);
    $display("reset and map test done");
    sleep_en_i <= 1'b1;
    wb(1'b1, `HWT_OFF_MASK, 32'h1);
    wb(1'b1, `HWT_OFF_PRELOAD, 32'h5);
    wait_wake();
    `CHK(n inside {[45:70]}, 1'b1)
    repeat (3) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    `CHK(clk_req_o, 1'b0)
    repeat (40) @(posedge clk_i);
    rdc(`HWT_OFF_COUNT, 32'h0);
    rdc(`HWT_OFF_STATUS, 32'h1);
    wb(1'b1, `HWT_OFF_STATUS, 32'h1);
    repeat (3) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    $display("fine countdown test done");
    wb(1'b1, `HWT_OFF_PRELOAD, 32'h100);
    repeat (40) @(posedge clk_i);
    wb(1'b0, `HWT_OFF_COUNT, 32'h0);
    `CHK(rd[15:0] inside {[16'h00F8:16'h00FF]}, 1'b1)
    // enable low for ten low-speed periods: the count may drop by at most 2
    held_count = rd[15:0];
    ce_i <= 1'b0;
    repeat (100) @(posedge clk_i);
    ce_i <= 1'b1;
    wb(1'b0, `HWT_OFF_COUNT, 32'h0);
    `CHK((held_count - rd[15:0]) <= 16'h0002, 1'b1)
    wb(1'b1, `HWT_OFF_PRELOAD, 32'h0);
    repeat (20) @(posedge clk_i);
    rdc(`HWT_OFF_COUNT, 32'h0);
    // stop a short count before it ends: no wake may follow
    wb(1'b1, `HWT_OFF_PRELOAD, 32'h3);
    repeat (15) @(posedge clk_i);
    wb(1'b1, `HWT_OFF_PRELOAD, 32'h0);
    n = 0;
    repeat (300) begin
      @(posedge clk_i);
      if (wake_interrupt_event_o !== 1'b0) n++;
    end
    `CHK(n, 0)
    $display("disable test done");
    wb(1'b1, `HWT_OFF_MASK, 32'h0);
    wb(1'b1, `HWT_OFF_CTRL, 32'h1);
    rdc(`HWT_OFF_CTRL, 32'h1);
    wb(1'b1, `HWT_OFF_PRELOAD, 32'h2);
    wait_wake();
    `CHK(n inside {[75:95]}, 1'b1)
    repeat (3) @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    rdc(`HWT_OFF_STATUS, 32'h1);
    $display("coarse and mask test done");
    wb(1'b1, `HWT_OFF_PRELOAD, 32'h40);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`HWT_OFF_PRELOAD, 32'h0);
    rdc(`HWT_OFF_CTRL, 32'h0);
    rdc(`HWT_OFF_STATUS, 32'h0);
    rdc(`HWT_OFF_COUNT, 32'h0);
    $display("mid-run reset test done");
    complete_run();
  end
endmodule : hwt_wake_timer_bench
